// File: verilog/cca_cfg.svh
/*
 Constants for the counter capture array: reset values and prescale counts.
 Assumes inclusion by bare name wherever the counter array logic needs them.
*/
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH
`define CCA_CNT_RST      16'h0000
`define CCA_WDOG_LIM_RST 16'hFFFF
`define CCA_DIV12_LAST   4'hB
`define CCA_DIV4_LAST    4'h3
`define CCA_XOSC8_LAST   3'h7
`define CCA_CNT_MAX      16'hFFFF
`endif

// File: verilog/cca_pkg.sv
/*
 Types shared by the counter capture array: clock sources, module modes and
 the per-module configuration carrier. Assumes nothing of its surroundings.
*/
package cca_pkg;
    typedef enum logic [2:0] {
        CCA_SRC_DIV12 = 3'h0,
        CCA_SRC_DIV4  = 3'h1,
        CCA_SRC_T0OV  = 3'h2,
        CCA_SRC_XCNT  = 3'h3,
        CCA_SRC_SYS   = 3'h4,
        CCA_SRC_XOSC8 = 3'h5
    } cca_src_t;

    typedef enum logic [2:0] {
        CCA_MODE_CAPTURE = 3'h0,
        CCA_MODE_SWTIMER = 3'h1,
        CCA_MODE_HSO     = 3'h2,
        CCA_MODE_PWM8    = 3'h3,
        CCA_MODE_PWM16   = 3'h4,
        CCA_MODE_FREQ    = 3'h5,
        CCA_MODE_OFF     = 3'h6
    } cca_mode_t;

    typedef struct packed {
        cca_mode_t   mode;
        logic [15:0] cmp;
        logic        cap_rise;
        logic        cap_fall;
    } cca_ccm_cfg_t;
endpackage : cca_pkg

// File: verilog/cca_counter_capture_array.sv
/*
 Counter capture array: one 16-bit time base, six selectable clock sources,
 three capture/compare modules and a watchdog function on module 2.
 Assumes pins arrive asynchronously through the crossbar and that the timer 0
 overflow pulse and all configuration ports come from logic on clk_in.
*/
`timescale 1ns/1ps
`include "cca_cfg.svh"

// Function
// - One 16-bit counter is the shared time base of all three modules.
// - The counter tick comes from sysclk/12, sysclk/4, timer 0 overflow, the external count input, sysclk or external oscillator/8.
// - Each module runs as capture, software timer, high-speed output, 8-bit PWM, 16-bit PWM or frequency output.
// - Module 2 can also serve as a watchdog timer function.
// - After every reset module 2 is already enabled as watchdog without software action.
// - Module pins and the external count input are plain ports that the crossbar routes.
// - The counter and its prescalers stand still while the processor is halted under debug; capture inputs still latch the held count.
// - The counter can run from the external oscillator while the system clock runs elsewhere.
module cca_counter_capture_array (
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  run_in,
    input  wire logic                  dbg_halt_in,
    input  wire cca_pkg::cca_src_t     src_sel_in,
    input  wire logic                  t0_ovf_in,
    input  wire logic                  xcnt_pin_in,
    input  wire logic                  xosc_in,
    input  wire logic [2:0]            ccm_pin_in,
    input  wire cca_pkg::cca_ccm_cfg_t ccm_cfg_in [3],
    input  wire logic [2:0]            cap_clr_in,
    input  wire logic [2:0]            match_clr_in,
    input  wire logic                  ovf_clr_in,
    input  wire logic                  wdog_dis_in,
    input  wire logic                  wdog_kick_in,
    input  wire logic [15:0]           wdog_span_in,
    output logic [15:0]                count_out,
    output logic                       ovf_flag_out,
    output logic [2:0]                 ccm_pin_out,
    output logic [2:0]                 cap_flag_out,
    output logic [2:0]                 match_flag_out,
    output logic [15:0]                cap_val_out [3],
    output logic                       wdog_en_out,
    output logic                       wdog_rst_out
);
    logic [4:0]  s1_r;
    logic [4:0]  s2_r;
    logic [4:0]  s3_r;
    logic [4:0]  lvl_r;
    logic [4:0]  rise_r;
    logic [4:0]  fall_r;
    logic [3:0]  div12_r;
    logic [1:0]  div4_r;
    logic [2:0]  xosc8_r;
    logic        tick;
    logic        run_ok;
    logic [15:0] cnt_r;
    logic [15:0] wdog_lim_r;
    logic [7:0]  freq_r [3];

    // Returns whether the counter value equals the compare value.
    function automatic logic cca_hit(input logic [15:0] cnt, input logic [15:0] cmp);
        cca_hit = (cnt == cmp);
    endfunction : cca_hit

    // Three-stage synchroniser for the pins; a level counts once stages two and three agree.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s1_r   <= 5'h00;
            s2_r   <= 5'h00;
            s3_r   <= 5'h00;
            lvl_r  <= 5'h00;
            rise_r <= 5'h00;
            fall_r <= 5'h00;
        end else begin
            s1_r   <= {xosc_in, xcnt_pin_in, ccm_pin_in};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            lvl_r  <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
            rise_r <= s2_r & s3_r & ~lvl_r;
            fall_r <= ~s2_r & ~s3_r & lvl_r;
        end
    end

    assign run_ok = run_in & ~dbg_halt_in;

    // Prescalers for the divided sources; they freeze with the counter under debug halt.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            div12_r <= 4'h0;
            div4_r  <= 2'h0;
            xosc8_r <= 3'h0;
        end else if (run_ok) begin
            div12_r <= (div12_r == `CCA_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
            div4_r  <= div4_r + 2'h1;
            if (rise_r[4]) begin
                xosc8_r <= xosc8_r + 3'h1;
            end
        end
    end

    // Source selection; every source gives at most one tick per clk_in cycle.
    always_comb begin
        case (src_sel_in)
            cca_pkg::CCA_SRC_DIV12: tick = (div12_r == `CCA_DIV12_LAST);
            cca_pkg::CCA_SRC_DIV4:  tick = (div4_r == `CCA_DIV4_LAST);
            cca_pkg::CCA_SRC_T0OV:  tick = t0_ovf_in;
            cca_pkg::CCA_SRC_XCNT:  tick = rise_r[3];
            cca_pkg::CCA_SRC_SYS:   tick = 1'b1;
            cca_pkg::CCA_SRC_XOSC8: tick = rise_r[4] && (xosc8_r == `CCA_XOSC8_LAST);
            default:                tick = 1'b0;
        endcase
    end

    // Shared time base and its overflow flag; a new overflow wins over a clear.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_r        <= `CCA_CNT_RST;
            ovf_flag_out <= 1'b0;
        end else begin
            if (tick && run_ok) begin
                cnt_r <= cnt_r + 16'h0001;
            end
            ovf_flag_out <= (tick && run_ok && cnt_r == `CCA_CNT_MAX)
                            | (ovf_flag_out & ~ovf_clr_in);
        end
    end

    assign count_out = cnt_r;

    // Capture and compare modules; flags set by hardware win over a clear.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ccm_pin_out    <= 3'h0;
            cap_flag_out   <= 3'h0;
            match_flag_out <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                cap_val_out[i] <= 16'h0000;
                freq_r[i]      <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                logic cap_ev;
                logic hit;
                cap_ev = 1'b0;
                hit    = 1'b0;
                if (!(i == 2 && wdog_en_out)) begin
                    case (ccm_cfg_in[i].mode)
                        cca_pkg::CCA_MODE_CAPTURE: begin
                            cap_ev = (ccm_cfg_in[i].cap_rise & rise_r[i])
                                   | (ccm_cfg_in[i].cap_fall & fall_r[i]);
                        end
                        cca_pkg::CCA_MODE_SWTIMER: begin
                            hit = tick && run_ok && cca_hit(cnt_r, ccm_cfg_in[i].cmp);
                        end
                        cca_pkg::CCA_MODE_HSO: begin
                            hit = tick && run_ok && cca_hit(cnt_r, ccm_cfg_in[i].cmp);
                            if (hit) begin
                                ccm_pin_out[i] <= ~ccm_pin_out[i];
                            end
                        end
                        cca_pkg::CCA_MODE_PWM8: begin
                            ccm_pin_out[i] <= (cnt_r[7:0] < ccm_cfg_in[i].cmp[7:0]);
                        end
                        cca_pkg::CCA_MODE_PWM16: begin
                            ccm_pin_out[i] <= (cnt_r < ccm_cfg_in[i].cmp);
                        end
                        cca_pkg::CCA_MODE_FREQ: begin
                            // Toggle each time the low byte reaches the moving target.
                            if (tick && run_ok && cnt_r[7:0] == freq_r[i]) begin
                                ccm_pin_out[i] <= ~ccm_pin_out[i];
                                freq_r[i]      <= freq_r[i] + ccm_cfg_in[i].cmp[15:8];
                                hit            = 1'b1;
                            end
                        end
                        default: begin
                            ccm_pin_out[i] <= 1'b0;
                        end
                    endcase
                end
                if (cap_ev) begin
                    cap_val_out[i] <= cnt_r;
                end
                cap_flag_out[i]   <= cap_ev | (cap_flag_out[i] & ~cap_clr_in[i]);
                match_flag_out[i] <= hit | (match_flag_out[i] & ~match_clr_in[i]);
            end
        end
    end

    // Watchdog on module 2: enabled out of reset, kicked by moving its limit ahead.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wdog_en_out  <= 1'b1;
            wdog_lim_r   <= `CCA_WDOG_LIM_RST;
            wdog_rst_out <= 1'b0;
        end else begin
            if (wdog_dis_in) begin
                wdog_en_out <= 1'b0;
            end
            if (wdog_kick_in) begin
                wdog_lim_r <= cnt_r + wdog_span_in;
            end
            wdog_rst_out <= wdog_en_out && !wdog_dis_in && tick && run_ok
                            && cca_hit(cnt_r, wdog_lim_r);
        end
    end

    default clocking cca_cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_counter_step: assert property (tick && run_ok |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("Counter did not advance on a tick.");
    a_sys_source: assert property (src_sel_in == cca_pkg::CCA_SRC_SYS && run_ok
        && $past(src_sel_in) == cca_pkg::CCA_SRC_SYS |-> tick)
        else $error("System clock source failed to tick.");
    a_div4_spacing: assert property (src_sel_in == cca_pkg::CCA_SRC_DIV4 && tick
        && run_ok ##1 (src_sel_in == cca_pkg::CCA_SRC_DIV4) [*3] |-> !tick)
        else $error("Divide by four ticked too soon.");
    a_halt_freeze: assert property (!run_ok |=> cnt_r == $past(cnt_r))
        else $error("Counter moved while halted.");
    a_hso_toggle: assert property (ccm_cfg_in[0].mode == cca_pkg::CCA_MODE_HSO
        && tick && run_ok && cnt_r == ccm_cfg_in[0].cmp |=> $changed(ccm_pin_out[0]))
        else $error("High-speed output did not toggle on match.");
    a_capture_value: assert property (ccm_cfg_in[1].mode == cca_pkg::CCA_MODE_CAPTURE
        && ccm_cfg_in[1].cap_rise && rise_r[1] |=> cap_val_out[1] == $past(cnt_r)
        && cap_flag_out[1])
        else $error("Capture lost its value or flag.");
    a_wdog_fire: assert property (wdog_en_out && !wdog_dis_in && tick && run_ok
        && cnt_r == wdog_lim_r |=> wdog_rst_out)
        else $error("Watchdog failed to fire at its limit.");
    a_wdog_reset_on: assert property ($rose(rst_b_in) |-> wdog_en_out)
        else $error("Watchdog not enabled after reset.");
    a_xcnt_once: assert property (rise_r[3] |=> !rise_r[3])
        else $error("External count edge counted twice.");
    a_xosc_div8: assert property (src_sel_in == cca_pkg::CCA_SRC_XOSC8 && tick && run_ok
        |=> xosc8_r == 3'h0)
        else $error("Oscillator prescaler did not wrap on its tick.");

    c_overflow: cover property (ovf_flag_out);
    c_wdog_fire: cover property (wdog_rst_out);
    c_capture:  cover property (|cap_flag_out);
    c_freq_out: cover property (ccm_cfg_in[2].mode == cca_pkg::CCA_MODE_FREQ && !wdog_en_out
        && $changed(ccm_pin_out[2]));
endmodule : cca_counter_capture_array

// File: test/cca_pin_model.sv
/*
 Far-side model of the crossbar pins: external count input and external oscillator.
 Assumes the bench calls its tasks; both pins stand low between bursts.
*/
`timescale 1ns/1ps
module cca_pin_model (
    output logic xcnt_pin_out,
    output logic xosc_out
);
    // Both pins idle low, and the oscillator stands still outside a burst.
    initial begin
        xcnt_pin_out = 1'b0;
        xosc_out     = 1'b0;
    end
    // Each pulse outlasts three system cycles, so the synchroniser sees it once.
    task automatic xcnt_pulses(input int n);
        repeat (n) begin
            #93 xcnt_pin_out = 1'b1;
            #93 xcnt_pin_out = 1'b0;
        end
    endtask : xcnt_pulses
    // Edges arrive well below a third of the system clock, in an unrelated phase.
    task automatic xosc_edges(input int n);
        repeat (n) begin
            #117 xosc_out = 1'b1;
            #117 xosc_out = 1'b0;
        end
    endtask : xosc_edges
endmodule : cca_pin_model

// File: test/testbench.sv
/*
 Self-checking bench for the counter capture array with random stimulus.
 Assumes the design and pin model are compiled first; drives at falling edges.
*/
`timescale 1ns/1ps
module testbench;
    logic clk_in, rst_b_in, run_in, dbg_halt_in, t0_ovf_in, ovf_clr_in, xcnt_pin, xosc;
    logic wdog_dis_in, wdog_kick_in, ovf_flag_out, wdog_en_out, wdog_rst_out, seen, hso_prev;
    logic [2:0] ccm_pin_in, cap_clr_in, match_clr_in, ccm_pin_out, cap_flag_out, match_flag_out;
    logic [15:0] wdog_span_in, count_out, c0, cmpv;
    logic [15:0] cap_val_out [3];
    logic [31:0] seed;
    cca_pkg::cca_src_t     src_sel_in;
    cca_pkg::cca_ccm_cfg_t cfg [3];
    int err_count, checks, n, k;
    cca_pkg::cca_src_t srcs [3] = '{cca_pkg::CCA_SRC_SYS, cca_pkg::CCA_SRC_DIV4, cca_pkg::CCA_SRC_DIV12};
    int divs [3] = '{1, 4, 12};

    cca_counter_capture_array i_cca_counter_capture_array (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .run_in(run_in), .dbg_halt_in(dbg_halt_in), .src_sel_in(src_sel_in), .t0_ovf_in(t0_ovf_in),
        .xcnt_pin_in(xcnt_pin), .xosc_in(xosc), .ccm_pin_in(ccm_pin_in), .ccm_cfg_in(cfg),
        .cap_clr_in(cap_clr_in), .match_clr_in(match_clr_in), .ovf_clr_in(ovf_clr_in),
        .wdog_dis_in(wdog_dis_in), .wdog_kick_in(wdog_kick_in), .wdog_span_in(wdog_span_in),
        .count_out(count_out), .ovf_flag_out(ovf_flag_out), .ccm_pin_out(ccm_pin_out),
        .cap_flag_out(cap_flag_out), .match_flag_out(match_flag_out), .cap_val_out(cap_val_out),
        .wdog_en_out(wdog_en_out), .wdog_rst_out(wdog_rst_out));
    cca_pin_model i_cca_pin_model (.xcnt_pin_out(xcnt_pin), .xosc_out(xosc));

    // The clock toggles every 10 ns, half of its 20 ns period.
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // Xorshift source, repeatable from its fixed seed.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic tick(input int c);
        repeat (c) @(negedge clk_in);
    endtask : tick
    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // A hang is cut short at 1800 us, about a third beyond the expected run length of about 1.3 ms.
    initial begin
        #1800us;
        err_count++;
        complete_run();
    end
    // Main sequence.
    initial begin
        {run_in, dbg_halt_in, t0_ovf_in, ovf_clr_in, wdog_dis_in, wdog_kick_in} = '0;
        {ccm_pin_in, cap_clr_in, match_clr_in} = '0;
        err_count = 0;
        checks = 0;
        seed = 32'h8E168C26;
        wdog_span_in = 16'h0000;
        src_sel_in = cca_pkg::CCA_SRC_SYS;
        for (int i = 0; i < 3; i++) cfg[i] = '{cca_pkg::CCA_MODE_OFF, 16'h0000, 1'b0, 1'b0};
        rst_b_in = 1'b0;
        tick(12);
        rst_b_in = 1'b1;
        chk("count_rst", 16'h0000, count_out);
        chk("wdog_en_rst", 16'h0001, {15'h0000, wdog_en_out});
        for (int i = 0; i < 3; i++) begin
            src_sel_in = srcs[i];
            c0 = count_out;
            run_in = 1'b1;
            tick(48);
            run_in = 1'b0;
            tick(3);
            chk("count_div", c0 + 16'(48 / divs[i]), count_out);
        end
        n = rnd() % 16 + 2;
        src_sel_in = cca_pkg::CCA_SRC_SYS;
        c0 = count_out;
        run_in = 1'b1;
        tick(4);
        dbg_halt_in = 1'b1;
        tick(n);
        dbg_halt_in = 1'b0;
        tick(20);
        run_in = 1'b0;
        tick(3);
        chk("count_halt", c0 + 16'h0018, count_out);
        src_sel_in = cca_pkg::CCA_SRC_T0OV;
        n = rnd() % 8 + 1;
        c0 = count_out;
        run_in = 1'b1;
        repeat (n) begin
            t0_ovf_in = 1'b1;
            tick(1);
            t0_ovf_in = 1'b0;
            tick(rnd() % 3 + 1);
        end
        tick(3);
        chk("count_t0", c0 + 16'(n), count_out);
        src_sel_in = cca_pkg::CCA_SRC_XCNT;
        n = rnd() % 6 + 2;
        c0 = count_out;
        i_cca_pin_model.xcnt_pulses(n);
        tick(8);
        chk("count_xcnt", c0 + 16'(n), count_out);
        src_sel_in = cca_pkg::CCA_SRC_XOSC8;
        c0 = count_out;
        i_cca_pin_model.xosc_edges(32);
        tick(8);
        chk("count_xosc", c0 + 16'h0004, count_out);
        run_in = 1'b0;
        for (int m = 0; m < 7; m++) begin
            cfg[0].mode = cca_pkg::cca_mode_t'(m);
            tick(3);
        end
        chk("pin_off", 16'h0000, {15'h0000, ccm_pin_out[0]});
        for (int i = 0; i < 4; i++) begin
            cmpv = rnd();
            cfg[0] = '{cca_pkg::CCA_MODE_PWM16, cmpv, 1'b0, 1'b0};
            cfg[1] = '{cca_pkg::CCA_MODE_PWM8, cmpv, 1'b0, 1'b0};
            tick(3);
            chk("pwm16", {15'h0000, count_out < cmpv}, {15'h0000, ccm_pin_out[0]});
            chk("pwm8", {15'h0000, count_out[7:0] < cmpv[7:0]}, {15'h0000, ccm_pin_out[1]});
        end
        src_sel_in = cca_pkg::CCA_SRC_SYS;
        cfg[0] = '{cca_pkg::CCA_MODE_SWTIMER, count_out + 16'h0008, 1'b0, 1'b0};
        cfg[1] = '{cca_pkg::CCA_MODE_CAPTURE, 16'h0000, 1'b1, 1'b0};
        match_clr_in = 3'h7;
        cap_clr_in = 3'h7;
        tick(1);
        {match_clr_in, cap_clr_in} = '0;
        run_in = 1'b1;
        tick(4);
        chk("match_early", 16'h0000, {15'h0000, match_flag_out[0]});
        tick(8);
        chk("match_hit", 16'h0001, {15'h0000, match_flag_out[0]});
        run_in = 1'b0;
        tick(2);
        ccm_pin_in[1] = 1'b1;
        tick(8);
        chk("cap_flag", 16'h0001, {15'h0000, cap_flag_out[1]});
        chk("cap_val", count_out, cap_val_out[1]);
        cap_clr_in[1] = 1'b1;
        tick(1);
        cap_clr_in[1] = 1'b0;
        ccm_pin_in[1] = 1'b0;
        tick(8);
        chk("cap_fall", 16'h0000, {15'h0000, cap_flag_out[1]});
        wdog_span_in = 16'(rnd() % 32 + 16);
        wdog_kick_in = 1'b1;
        tick(1);
        wdog_kick_in = 1'b0;
        run_in = 1'b1;
        k = 0;
        while (wdog_rst_out !== 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        chk("wdog_fire", 16'h0001, {15'h0000, k >= int'(wdog_span_in) - 1 && k <= int'(wdog_span_in) + 3});
        wdog_dis_in = 1'b1;
        tick(1);
        wdog_dis_in = 1'b0;
        wdog_span_in = 16'h0004;
        wdog_kick_in = 1'b1;
        tick(1);
        wdog_kick_in = 1'b0;
        seen = 1'b0;
        repeat (40) begin
            tick(1);
            seen = seen | wdog_rst_out;
        end
        chk("wdog_off", 16'h0000, {14'h0000, wdog_en_out, seen});
        // High-speed output toggles its pin once when the running count meets the target.
        hso_prev = ccm_pin_out[0];
        cfg[0] = '{cca_pkg::CCA_MODE_HSO, count_out + 16'h0004, 1'b0, 1'b0};
        tick(8);
        chk("hso_pin", {15'h0000, ~hso_prev}, {15'h0000, ccm_pin_out[0]});
        // Let the counter wrap and check the sticky overflow flag.
        ovf_clr_in = 1'b1;
        tick(1);
        ovf_clr_in = 1'b0;
        chk("ovf_clear", 16'h0000, {15'h0000, ovf_flag_out});
        while (count_out !== 16'hFFFF) tick(1);
        tick(1);
        chk("ovf_wrap", 16'h0001, {15'h0000, ovf_flag_out});
        chk("count_wrap", 16'h0000, count_out);
        run_in = 1'b0;
        rst_b_in = 1'b0;
        tick(2);
        rst_b_in = 1'b1;
        tick(1);
        chk("wdog_en_rerst", 16'h0001, {15'h0000, wdog_en_out});
        complete_run();
    end
endmodule : testbench
